// ==== logic/cca_pkg.sv ====
package cca_pkg;

    // ********************************************************
    // Register word indices (byte address is four times these)
    // ********************************************************
    localparam logic [9:0] IDX_CHAN_SEL = 10'h0D1;
    localparam logic [9:0] IDX_DATA_HIGH = 10'h0D2;
    localparam logic [9:0] IDX_DATA_LOW = 10'h0D3;
    localparam logic [9:0] IDX_EVENT_FLAGS = 10'h0D5;
    localparam logic [9:0] IDX_CTRL = 10'h0D8;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0D9;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_GEN_BIT = 8;
    localparam int NUM_CHAN = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [1:0] RST_CHAN_SEL = 2'h0;
    localparam logic [7:0] RST_SHADOW = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_MASK = 4'h0;
    localparam logic [15:0] RST_DATA = 16'h0000;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [0:0] {
        PH_IDLE,
        PH_DONE
    } cca_phase_e;

    typedef struct packed {
        logic [1:0] chan_sel;
        logic [7:0] shadow;
        logic [3:0] cmp_mode;
        logic glob_en;
        logic [3:0] irq_mask;
        logic [3:0] flags;
        cca_phase_e phase;
        logic [31:0] prdata;
        logic slverr;
    } cca_state_s;

    typedef struct packed {
        logic [3:0][15:0] data;
        logic [15:0] rdata;
    } cca_mem_s;

endpackage

// ==== logic/cca_mem_if.sv ====
`timescale 1ns/1ps
interface cca_mem_if;
    logic [3:0] we;
    logic [3:0][15:0] wdata;
    logic [1:0] raddr;
    logic [15:0] rdata;
    logic [3:0][15:0] data;

    // Controller side drives writes and read index
    modport ctl (output we, output wdata, output raddr, input rdata, input data);
    // Storage side
    modport mem (input we, input wdata, input raddr, output rdata, output data);
endinterface

// ==== logic/cca_data_mem.sv ====
`timescale 1ns/1ps
module cca_data_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    cca_mem_if.mem mif
);

    cca_pkg::cca_mem_s s_q;
    cca_pkg::cca_mem_s s_d;

    // Per-entry writes; captures on several channels may land together
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < cca_pkg::NUM_CHAN; i++) begin
            if (mif.we[i]) begin
                s_d.data[i] = mif.wdata[i];
            end
        end
        // Read data is the pre-write value, registered
        s_d.rdata = s_q.data[mif.raddr];
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{data: {4{cca_pkg::RST_DATA}}, rdata: cca_pkg::RST_DATA};
        end else begin
            s_q <= s_d;
        end
    end

    assign mif.rdata = s_q.rdata;
    assign mif.data = s_q.data;

endmodule // cca_data_mem

// ==== logic/cca_data_flags.sv ====
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module cca_data_flags (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [3:0] EVENT_I,
    input wire logic [15:0] CAP_VALUE_I,
    output logic [63:0] CHAN_DATA_O,
    output logic [3:0] CMP_MODE_O,
    output logic IRQ_O
);

    // ********************************************************
    // Declarations
    // ********************************************************
    cca_pkg::cca_state_s s_q;
    cca_pkg::cca_state_s s_d;
    cca_mem_if mif ();
    logic [9:0] word;
    logic addr_hit;
    logic done;
    logic wr_done;
    logic wr_low;
    logic [3:0] flag_clr;
    logic [3:0] irq_req;
    logic [31:0] rd_val;

    // ********************************************************
    // Data storage
    // ********************************************************
    cca_data_mem u_mem (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .mif(mif.mem)
    );

    // Only the indexed channel is ever read back
    assign mif.raddr = s_q.chan_sel;

    // ********************************************************
    // Bus decode
    // ********************************************************
    // Upper two address bits must be zero to hit a register
    assign word = PADDR_I[11:2];
    assign done = PSEL_I & PENABLE_I & (s_q.phase == cca_pkg::PH_DONE);
    assign wr_done = done & PWRITE_I & addr_hit;
    assign wr_low = wr_done & (word == cca_pkg::IDX_DATA_LOW);

    // Address hit and read value
    always_comb begin
        addr_hit = 1'b1;
        rd_val = 32'h00000000;
        unique case (word)
            cca_pkg::IDX_CHAN_SEL: begin
                rd_val[1:0] = s_q.chan_sel;
            end
            cca_pkg::IDX_DATA_HIGH: begin
                rd_val[7:0] = mif.rdata[15:8];
            end
            cca_pkg::IDX_DATA_LOW: begin
                rd_val[7:0] = mif.rdata[7:0];
            end
            cca_pkg::IDX_EVENT_FLAGS: begin
                rd_val[3:0] = s_q.flags;
            end
            cca_pkg::IDX_CTRL: begin
                rd_val[cca_pkg::CTRL_MODE_LSB +: 4] = s_q.cmp_mode;
                rd_val[cca_pkg::CTRL_GEN_BIT] = s_q.glob_en;
            end
            cca_pkg::IDX_IRQ_MASK: begin
                rd_val[3:0] = s_q.irq_mask;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Write-one-to-clear mask for the flag register
    always_comb begin
        flag_clr = 4'h0;
        if (wr_done && word == cca_pkg::IDX_EVENT_FLAGS) begin
            flag_clr = PWDATA_I[3:0];
        end
    end

    // ********************************************************
    // Per-channel data writes
    // ********************************************************
    // Capture and software write never meet on one channel,
    // since software may write only compare-mode channels
    for (genvar ch = 0; ch < cca_pkg::NUM_CHAN; ch++) begin : g_chan
        logic cap_ld;
        logic sw_ld;
        assign cap_ld = EVENT_I[ch] & ~s_q.cmp_mode[ch];
        // Indexed channel only, compare mode only
        assign sw_ld = wr_low & (s_q.chan_sel == 2'(ch))
            & s_q.cmp_mode[ch];
        assign mif.we[ch] = cap_ld | sw_ld;
        // Shadow supplies the high byte in the same write
        assign mif.wdata[ch] = cap_ld ? CAP_VALUE_I
            : {s_q.shadow, PWDATA_I[7:0]};
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_d = s_q;
        // One wait state gives the memory time to present data
        if (s_q.phase == cca_pkg::PH_IDLE && PSEL_I && PENABLE_I) begin
            s_d.phase = cca_pkg::PH_DONE;
            s_d.prdata = rd_val;
            s_d.slverr = ~addr_hit;
        end
        if (done) begin
            s_d.phase = cca_pkg::PH_IDLE;
        end
        // Register writes take effect on the completing edge
        if (wr_done) begin
            unique case (word)
                cca_pkg::IDX_CHAN_SEL: begin
                    s_d.chan_sel = PWDATA_I[1:0];
                end
                cca_pkg::IDX_DATA_HIGH: begin
                    s_d.shadow = PWDATA_I[7:0];
                end
                cca_pkg::IDX_CTRL: begin
                    s_d.cmp_mode = PWDATA_I[cca_pkg::CTRL_MODE_LSB +: 4];
                    s_d.glob_en = PWDATA_I[cca_pkg::CTRL_GEN_BIT];
                end
                cca_pkg::IDX_IRQ_MASK: begin
                    s_d.irq_mask = PWDATA_I[3:0];
                end
                default: begin
                end
            endcase
        end
        // Sticky flags; a new event beats a clear
        s_d.flags = (s_q.flags & ~flag_clr) | EVENT_I;
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_q <= '{
                chan_sel: cca_pkg::RST_CHAN_SEL,
                shadow: cca_pkg::RST_SHADOW,
                cmp_mode: cca_pkg::RST_MODE,
                glob_en: 1'b0,
                irq_mask: cca_pkg::RST_MASK,
                flags: cca_pkg::RST_FLAGS,
                phase: cca_pkg::PH_IDLE,
                prdata: 32'h00000000,
                slverr: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Both enables gate each flag before the OR
    assign irq_req = s_q.flags & s_q.irq_mask & {4{s_q.glob_en}};
    assign IRQ_O = |irq_req;
    assign PRDATA_O = s_q.prdata;
    assign PREADY_O = PSEL_I & PENABLE_I & (s_q.phase == cca_pkg::PH_DONE);
    assign PSLVERR_O = PREADY_O & s_q.slverr;
    assign CHAN_DATA_O = mif.data;
    assign CMP_MODE_O = s_q.cmp_mode;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    logic [15:0] sel_data;
    logic [3:0] chan_onehot;
    assign sel_data = mif.data[s_q.chan_sel];
    assign chan_onehot = 4'h1 << s_q.chan_sel;

    // Low read returns indexed low byte, two edges stale
    a_low_read: assert property (
        (done && !PWRITE_I && word == cca_pkg::IDX_DATA_LOW)
        |-> PRDATA_O == {24'h000000, $past(sel_data[7:0], 2)})
        else $error("low port read mismatch");

    // High read returns indexed high byte
    a_high_read: assert property (
        (done && !PWRITE_I && word == cca_pkg::IDX_DATA_HIGH)
        |-> PRDATA_O == {24'h000000, $past(sel_data[15:8], 2)})
        else $error("high port read mismatch");

    // Compare-mode low write loads shadow and byte together
    a_low_write: assert property (
        (wr_low && s_q.cmp_mode[s_q.chan_sel])
        |=> sel_data == {$past(s_q.shadow), $past(PWDATA_I[7:0])})
        else $error("low write did not load word");

    // Capture-mode channel ignores software writes
    a_cap_locked: assert property (
        (wr_low && !s_q.cmp_mode[s_q.chan_sel]
            && !(|(EVENT_I & chan_onehot)))
        |=> $stable(sel_data))
        else $error("capture channel was written");

    // Other channels keep their data across a low write
    a_others_kept: assert property (
        (wr_low && EVENT_I == 4'h0)
        ##1 1'b1 |-> (mif.data[0] == $past(mif.data[0]) || $past(s_q.chan_sel) == 2'h0)
            && (mif.data[1] == $past(mif.data[1]) || $past(s_q.chan_sel) == 2'h1)
            && (mif.data[2] == $past(mif.data[2]) || $past(s_q.chan_sel) == 2'h2)
            && (mif.data[3] == $past(mif.data[3]) || $past(s_q.chan_sel) == 2'h3))
        else $error("unindexed channel changed");

    // High write loads the shadow and leaves all channel data as it was
    a_shadow_kept: assert property (
        (wr_done && word == cca_pkg::IDX_DATA_HIGH && EVENT_I == 4'h0)
        |=> s_q.shadow == $past(PWDATA_I[7:0]) && $stable(mif.data))
        else $error("high write misbehaved");

    // Data and shadow are zero straight after reset
    a_reset_zero: assert property (
        $past(RST_I) |-> mif.data == 64'h0 && s_q.shadow == 8'h00)
        else $error("data not zero after reset");

    // Index write selects the channel
    a_index_sel: assert property (
        (wr_done && word == cca_pkg::IDX_CHAN_SEL)
        |=> s_q.chan_sel == $past(PWDATA_I[1:0]))
        else $error("channel index not updated");

    // Event sets the flag even against a clear
    a_flag_set: assert property (
        EVENT_I[0] |=> s_q.flags[0])
        else $error("event lost on flag A");

    // Only a software clear drops a flag
    a_flag_hold: assert property (
        (s_q.flags[2] && !flag_clr[2]) |=> s_q.flags[2] [*1])
        else $error("flag C dropped by hardware");

    // Flag register reads with upper bits zero
    a_flag_read: assert property (
        (done && !PWRITE_I && word == cca_pkg::IDX_EVENT_FLAGS)
        |-> PRDATA_O[31:4] == 28'h0 && PRDATA_O[3:0] == $past(s_q.flags))
        else $error("flag register layout wrong");

    // Request only with both enables
    a_irq_gate: assert property (
        IRQ_O |-> s_q.glob_en && (|(s_q.flags & s_q.irq_mask)))
        else $error("interrupt without enable");

    // Any gated flag raises the single request
    a_irq_any: assert property (
        (s_q.glob_en && (|(s_q.flags & s_q.irq_mask))) |-> IRQ_O)
        else $error("interrupt missing");

    // Gated event raises the request one cycle later
    a_irq_follow: assert property (
        (s_q.glob_en && (|(EVENT_I & s_q.irq_mask)) && !wr_done)
        |=> IRQ_O)
        else $error("interrupt late after event");

    // Dropping the global enable silences every flag
    a_irq_global: assert property (
        (wr_done && word == cca_pkg::IDX_CTRL && !PWDATA_I[cca_pkg::CTRL_GEN_BIT])
        |=> !IRQ_O)
        else $error("interrupt without global enable");

    // ********************************************************
    // Bus handshake checks
    // ********************************************************
    // First access cycle after setup is always a wait state
    a_first_wait: assert property (
        (PSEL_I && !PENABLE_I) ##1 (PSEL_I && PENABLE_I) |-> !PREADY_O)
        else $error("ready without a wait state");

    // Second access cycle always answers; no master waits longer
    a_second_ready: assert property (
        (PSEL_I && PENABLE_I && !PREADY_O) ##1 (PSEL_I && PENABLE_I) |-> PREADY_O)
        else $error("ready missing on second access");

    // Error answer marks exactly the unmapped words
    a_err_map: assert property (
        PREADY_O |-> PSLVERR_O == !addr_hit)
        else $error("error answer does not match map");

    // ********************************************************
    // Per-channel flag and data checks
    // ********************************************************
    // One copy per channel so that no flag goes unwatched
    for (genvar fc = 0; fc < cca_pkg::NUM_CHAN; fc++) begin : g_chan_chk
        // An event lands whatever software writes that cycle
        a_event_sets: assert property (
            EVENT_I[fc] |=> s_q.flags[fc])
            else $error("event did not set its flag");

        // A written one without an event clears the flag
        a_clear_works: assert property (
            (flag_clr[fc] && !EVENT_I[fc]) |=> !s_q.flags[fc])
            else $error("flag not cleared by a written one");

        // Without a written one a set flag stays set
        a_flag_sticky: assert property (
            (s_q.flags[fc] && !flag_clr[fc]) |=> s_q.flags[fc])
            else $error("flag dropped without a clear");

        // A capture-mode event stores the time base value
        a_cap_store: assert property (
            (EVENT_I[fc] && !s_q.cmp_mode[fc]) |=> mif.data[fc] == $past(CAP_VALUE_I))
            else $error("capture value not stored");

        // A compare-mode channel changes only by its own write
        a_cmp_kept: assert property (
            (s_q.cmp_mode[fc] && !(wr_low && s_q.chan_sel == 2'(fc)))
            |=> $stable(mif.data[fc]))
            else $error("compare channel changed without a write");
    end

endmodule // cca_data_flags

// ==== tb/cca_data_flags_test.sv ====
`timescale 1ns/1ps
module cca_data_flags_test;
    // ********************************************************
    // Signals
    // ********************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] ev = 4'h0;
    logic [15:0] cap = 16'h0000;
    logic [63:0] chan_data;
    logic [3:0] cmp_mode;
    logic irq;
    logic [3:0][15:0] model;
    int bad_count = 0;
    int checks = 0;

    cca_data_flags cca_data_flags_i (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EVENT_I(ev), .CAP_VALUE_I(cap),
        .CHAN_DATA_O(chan_data), .CMP_MODE_O(cmp_mode), .IRQ_O(irq)
    );

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic close_out();
        $display("Mismatches %0d of %0d comparisons", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error are all taken at the completing edge
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle, so psel is never driven twice in one step
        @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h00000000, r, e);
        chk(r, exp);
        chk(e, experr);
    endtask

    // One-cycle event strobe, optionally with a capture value
    task automatic pulse(input logic [3:0] v, input logic [15:0] c);
        ev <= v;
        cap <= c;
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset();
        rdchk(cca_pkg::IDX_DATA_HIGH, 32'h00000000, 1'b0);
        rdchk(cca_pkg::IDX_DATA_LOW, 32'h00000000, 1'b0);
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000000, 1'b0);
        rdchk(cca_pkg::IDX_CHAN_SEL, 32'h00000000, 1'b0);
        chk(chan_data, 64'h0000000000000000);
        chk(irq, 1'b0);
    endtask

    // Each channel written through the ports, then read back in reverse
    task automatic t_data();
        wr(cca_pkg::IDX_CTRL, 32'h0000000F);
        chk(cmp_mode, 4'hF);
        model = '0;
        for (int ch = 0; ch < 4; ch++) begin
            wr(cca_pkg::IDX_CHAN_SEL, ch);
            wr(cca_pkg::IDX_DATA_HIGH, 32'h30 + ch);
            wr(cca_pkg::IDX_DATA_LOW, 32'hC0 + ch);
            model[ch] = {8'h30 + 8'(ch), 8'hC0 + 8'(ch)};
            chk(chan_data, model);
        end
        for (int ch = 3; ch >= 0; ch--) begin
            wr(cca_pkg::IDX_CHAN_SEL, ch);
            rdchk(cca_pkg::IDX_DATA_HIGH, model[ch][15:8], 1'b0);
            rdchk(cca_pkg::IDX_DATA_LOW, model[ch][7:0], 1'b0);
        end
        // Shadow keeps the last high byte, written for channel D
        wr(cca_pkg::IDX_CHAN_SEL, 32'h1);
        rdchk(cca_pkg::IDX_CHAN_SEL, 32'h1, 1'b0);
        wr(cca_pkg::IDX_DATA_LOW, 32'h5A);
        model[1] = 16'h335A;
        chk(chan_data, model);
    endtask

    // Channel C in capture mode: software write refused, event loads it
    task automatic t_capture();
        wr(cca_pkg::IDX_CTRL, 32'h0000000B);
        wr(cca_pkg::IDX_CHAN_SEL, 32'h2);
        wr(cca_pkg::IDX_DATA_HIGH, 32'hEE);
        wr(cca_pkg::IDX_DATA_LOW, 32'h77);
        chk(chan_data, model);
        pulse(4'h4, 16'hBEEF);
        model[2] = 16'hBEEF;
        chk(chan_data, model);
        pulse(4'h1, 16'h1234);
        chk(chan_data, model);
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000005, 1'b0);
    endtask

    // Interrupt gating, sticky flags and write-one-to-clear
    task automatic t_irq();
        chk(irq, 1'b0);
        wr(cca_pkg::IDX_IRQ_MASK, 32'h4);
        chk(irq, 1'b0);
        wr(cca_pkg::IDX_CTRL, 32'h0000000B | (32'h1 << cca_pkg::CTRL_GEN_BIT));
        chk(irq, 1'b1);
        wr(cca_pkg::IDX_IRQ_MASK, 32'h2);
        chk(irq, 1'b0);
        wr(cca_pkg::IDX_IRQ_MASK, 32'hF);
        chk(irq, 1'b1);
        wr(cca_pkg::IDX_EVENT_FLAGS, 32'hF0);
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000005, 1'b0);
        wr(cca_pkg::IDX_EVENT_FLAGS, 32'h04);
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000001, 1'b0);
        chk(irq, 1'b1);
        wr(cca_pkg::IDX_EVENT_FLAGS, 32'h01);
        chk(irq, 1'b0);
    endtask

    // Event lands on the very edge that completes the clear
    task automatic t_race();
        pulse(4'h1, 16'h0000);
        fork
            wr(cca_pkg::IDX_EVENT_FLAGS, 32'h01);
            begin
                @(negedge clk);
                while (!(penable === 1'b1 && pready === 1'b0)) @(negedge clk);
                @(posedge clk);
                ev <= 4'h1;
                @(posedge clk);
                ev <= 4'h0;
            end
        join
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000001, 1'b0);
        chk(irq, 1'b1);
        wr(cca_pkg::IDX_EVENT_FLAGS, 32'h01);
    endtask

    // Unmapped word answers with an error and reads zero
    task automatic t_unmapped();
        wr(10'h0D7, 32'hFFFFFFFF);
        rdchk(10'h0D7, 32'h00000000, 1'b1);
        chk(chan_data, model);
    endtask

    // Reset in mid-run clears data, shadow, flags and modes again
    task automatic t_rereset();
        pulse(4'h2, 16'h0000);
        chk(irq, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        model = '0;
        chk(chan_data, model);
        chk(cmp_mode, 4'h0);
        chk(irq, 1'b0);
        rdchk(cca_pkg::IDX_DATA_HIGH, 32'h00000000, 1'b0);
        rdchk(cca_pkg::IDX_DATA_LOW, 32'h00000000, 1'b0);
        rdchk(cca_pkg::IDX_EVENT_FLAGS, 32'h00000000, 1'b0);
    endtask

    // ********************************************************
    // Main sequence and watchdog
    // ********************************************************
    // Reset held five cycles, released on a rising edge
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_data();
        t_capture();
        t_irq();
        t_race();
        t_unmapped();
        t_rereset();
        close_out();
    end

    // Roughly twenty times the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule // cca_data_flags_test
